// file: cpgw_pkg.sv
/*
  shared constants and types of the configuration port, the general
  purpose i/o device and the watchdog, for both ends of the link.
  assumes one 40 MHz clock on both ends.
*/
package cpgw_pkg;

  // ************************************************************
  // link ports and unlock keys
  // ************************************************************
  localparam logic [15:0] ADDR_PORT = 16'h002E;
  localparam logic [15:0] DATA_PORT = 16'h002F;
  localparam logic [7:0] KEY_FIRST = 8'h87;
  localparam logic [7:0] KEY_SECOND = 8'h01;
  localparam logic [7:0] KEY_THIRD = 8'h55;
  localparam logic [7:0] LOCK_KEY = 8'hAA;
  localparam logic [7:0] IDLE_READ = 8'hFF;

  // ************************************************************
  // register indexes
  // ************************************************************
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] LDN_GPIO = 8'h07;
  localparam logic [7:0] LDN_WDT = 8'h08;
  localparam logic [7:0] IDX_OUT_PORT = 8'h60;
  localparam logic [7:0] IDX_IN_PORT = 8'h62;
  localparam logic [7:0] IDX_GPO_DATA = 8'hE5;
  localparam logic [7:0] IDX_GPI_DATA = 8'hF1;
  localparam logic [7:0] IDX_WDT_ACT = 8'h30;
  localparam logic [7:0] IDX_WDT_CTL = 8'hF0;
  localparam logic [7:0] IDX_WDT_TO = 8'hF1;
  localparam logic [7:0] IDX_WDT_STS = 8'hF2;
  localparam logic [7:0] IDX_WDT_CLR = 8'hF3;
  localparam logic [7:0] IDX_WDT_IEN = 8'hF4;
  localparam logic [7:0] WDT_ON = 8'h01;
  localparam logic [7:0] CNT_START = 8'h02;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_TIME_MS = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_TIME_MS;

  // ************************************************************
  // host command registers (avalon byte addresses)
  // ************************************************************
  localparam logic [3:0] HOST_CMD = 4'h0;
  localparam logic [3:0] HOST_STS = 4'h4;
  localparam int CMD_PORT_BIT = 8;
  localparam int CMD_READ_BIT = 9;
  localparam int STS_BUSY_BIT = 8;

  typedef enum logic [2:0] {UL_LOCKED, UL_KEY1, UL_KEY2, UL_KEY3, UL_OPEN} cpgw_unlock_e;
  typedef enum logic [0:0] {HS_IDLE, HS_IO} cpgw_host_e;

endpackage

// file: cpgw_io_if.sv
/*
  byte-wide i/o port link between the host bridge and the device.
  assumes both ends share ref_clk; the device answers with ready.
*/
`timescale 1ns/10ps
interface cpgw_io_if;
  logic [15:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic io_ready;

  modport dev (
    input io_addr,
    input io_wr,
    input io_rd,
    input io_wdata,
    output io_rdata,
    output io_ready
  );

  modport host (
    output io_addr,
    output io_wr,
    output io_rd,
    output io_wdata,
    input io_rdata,
    input io_ready
  );
endinterface

// file: cpgw_device.sv
/*
  device end: unlockable index/data configuration port, general purpose
  output and input ports, and a watchdog with sticky timeout status.
  assumes the host holds one request until ready and then drops it.
*/
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/10ps

module cpgw_device
  import cpgw_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  cpgw_io_if.dev io,
  input wire logic [7:0] gpi_pins,
  output logic [7:0] gpo_pins,
  output logic wdt_reset,
  output logic irq
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cpgw_unlock_e unlock;
    logic [7:0] index;
    logic [7:0] ldn;
    logic [7:0] out_idx;
    logic [7:0] in_idx;
    logic [7:0] general_output_port;
    logic [7:0] act;
    logic [7:0] ctl;
    logic [7:0] tmo;
    logic [7:0] cnt;
    logic [31:0] tick;
    logic sts;
    logic ien;
    logic ready;
    logic [7:0] rdata;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] general_input_port;
    logic wdt_rst;
    logic irq;
  } cpgw_dev_s;

  cpgw_dev_s s_q;
  cpgw_dev_s s_d;

  logic acc;
  logic on_addr;
  logic on_data;
  logic running;
  logic tick_ev;
  logic fire;
  logic [7:0] rd_val;

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb
  begin
    rd_val = RST_BYTE;
    if (s_q.index == IDX_LDN)
    begin
      rd_val = s_q.ldn;
    end
    else if (s_q.ldn == LDN_GPIO)
    begin
      case (s_q.index)
        IDX_OUT_PORT: rd_val = s_q.out_idx;
        IDX_IN_PORT: rd_val = s_q.in_idx;
        IDX_GPO_DATA: rd_val = s_q.general_output_port;
        IDX_GPI_DATA: rd_val = s_q.general_input_port;
        default: rd_val = RST_BYTE;
      endcase
    end
    else if (s_q.ldn == LDN_WDT)
    begin
      case (s_q.index)
        IDX_WDT_ACT: rd_val = s_q.act;
        IDX_WDT_CTL: rd_val = s_q.ctl;
        IDX_WDT_TO: rd_val = s_q.cnt;
        IDX_WDT_STS: rd_val = {7'h00, s_q.sts};
        IDX_WDT_IEN: rd_val = {7'h00, s_q.ien};
        default: rd_val = RST_BYTE;
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ready = 1'b0;
    s_d.wdt_rst = 1'b0;
    fire = 1'b0;
    tick_ev = 1'b0;

    // input pin synchroniser, change taken when stages two and three agree
    s_d.s1 = gpi_pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    if (s_q.s2 == s_q.s3)
    begin
      s_d.general_input_port = s_q.s3;
    end

    // watchdog countdown
    running = (s_q.act == WDT_ON) && (s_q.ctl == CNT_START) && (s_q.cnt != 8'h00);
    if (running)
    begin
      if (s_q.tick == 32'(TICK_CNT - 1))
      begin
        s_d.tick = 32'h00000000;
        tick_ev = 1'b1;
      end
      else
      begin
        s_d.tick = s_q.tick + 32'h00000001;
      end
    end
    else
    begin
      s_d.tick = 32'h00000000;
    end
    if (tick_ev)
    begin
      s_d.cnt = s_q.cnt - 8'h01;
      if (s_q.cnt == 8'h01)
      begin
        fire = 1'b1;
      end
    end

    // i/o port access
    on_addr = io.io_addr == ADDR_PORT;
    on_data = io.io_addr == DATA_PORT;
    acc = (io.io_wr || io.io_rd) && !s_q.ready && (on_addr || on_data);
    if (acc)
    begin
      s_d.ready = 1'b1;
      if (io.io_rd)
      begin
        s_d.rdata = IDLE_READ;
        if (on_data && s_q.unlock == UL_OPEN)
        begin
          s_d.rdata = rd_val;
        end
      end
      else if (on_addr)
      begin
        case (s_q.unlock)
          UL_LOCKED: s_d.unlock = (io.io_wdata == KEY_FIRST) ? UL_KEY1 : UL_LOCKED;
          UL_KEY1: s_d.unlock = (io.io_wdata == KEY_SECOND) ? UL_KEY2 : UL_LOCKED;
          UL_KEY2: s_d.unlock = (io.io_wdata == KEY_THIRD) ? UL_KEY3 : UL_LOCKED;
          UL_KEY3: s_d.unlock = (io.io_wdata == KEY_THIRD) ? UL_OPEN : UL_LOCKED;
          UL_OPEN:
          begin
            if (io.io_wdata == LOCK_KEY)
            begin
              s_d.unlock = UL_LOCKED;
            end
            else
            begin
              s_d.index = io.io_wdata;
            end
          end
          default: s_d.unlock = UL_LOCKED;
        endcase
      end
      else if (s_q.unlock == UL_OPEN)
      begin
        if (s_q.index == IDX_LDN)
        begin
          s_d.ldn = io.io_wdata;
        end
        else if (s_q.ldn == LDN_GPIO)
        begin
          case (s_q.index)
            IDX_OUT_PORT: s_d.out_idx = io.io_wdata;
            IDX_IN_PORT: s_d.in_idx = io.io_wdata;
            IDX_GPO_DATA: s_d.general_output_port = io.io_wdata;
            default: s_d.general_output_port = s_q.general_output_port;
          endcase
        end
        else if (s_q.ldn == LDN_WDT)
        begin
          case (s_q.index)
            IDX_WDT_ACT: s_d.act = io.io_wdata;
            IDX_WDT_CTL:
            begin
              s_d.ctl = io.io_wdata;
              if (io.io_wdata == CNT_START)
              begin
                s_d.cnt = s_q.tmo;
                s_d.tick = 32'h00000000;
                fire = 1'b0;
              end
            end
            IDX_WDT_TO:
            begin
              s_d.tmo = io.io_wdata;
              s_d.cnt = io.io_wdata;
              s_d.tick = 32'h00000000;
              fire = 1'b0;
            end
            IDX_WDT_CLR: s_d.sts = s_q.sts & ~io.io_wdata[0];
            IDX_WDT_IEN: s_d.ien = io.io_wdata[0];
            default: s_d.act = s_q.act;
          endcase
        end
      end
    end

    // timeout event, set wins over clear
    if (fire)
    begin
      s_d.wdt_rst = 1'b1;
      s_d.sts = 1'b1;
    end
    s_d.irq = s_d.sts & s_d.ien;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign gpo_pins = s_q.general_output_port;
  assign wdt_reset = s_q.wdt_rst;
  assign irq = s_q.irq;
  assign io.io_rdata = s_q.rdata;
  assign io.io_ready = s_q.ready;

endmodule // cpgw_device

// file: cpgw_host.sv
/*
  host end: avalon-mm slave with waitrequest that turns one command
  word into one byte-wide i/o cycle on the link and keeps the result.
  assumes software issues unlock, index and data bytes in order.
*/
`timescale 1ns/10ps
module cpgw_host
  import cpgw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  cpgw_io_if.host io
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    cpgw_host_e state;
    logic wait_n;
    logic [31:0] rdata;
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rx;
  } cpgw_hst_s;

  cpgw_hst_s s_q;
  cpgw_hst_s s_d;

  logic req;
  logic is_cmd;
  logic busy;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.wait_n = 1'b0;
    req = avs_read || avs_write;
    is_cmd = avs_address == HOST_CMD;
    busy = s_q.state != HS_IDLE;

    // answer: one cycle of waitrequest low, commands wait while busy
    if (req && !s_q.wait_n && !(avs_write && is_cmd && busy))
    begin
      s_d.wait_n = 1'b1;
      s_d.rdata = 32'h00000000;
      if (avs_read && avs_address == HOST_STS)
      begin
        s_d.rdata = {23'h000000, busy, s_q.rx};
      end
    end

    case (s_q.state)
      HS_IDLE:
      begin
        if (req && s_q.wait_n && avs_write && is_cmd)
        begin
          s_d.state = HS_IO;
          s_d.addr = avs_writedata[CMD_PORT_BIT] ? DATA_PORT : ADDR_PORT;
          s_d.rd = avs_writedata[CMD_READ_BIT];
          s_d.wr = !avs_writedata[CMD_READ_BIT];
          s_d.wdata = avs_writedata[7:0];
        end
      end
      HS_IO:
      begin
        if (io.io_ready)
        begin
          s_d.state = HS_IDLE;
          s_d.wr = 1'b0;
          s_d.rd = 1'b0;
          if (s_q.rd)
          begin
            s_d.rx = io.io_rdata;
          end
        end
      end
      default: s_d.state = HS_IDLE;
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = !s_q.wait_n;
  assign io.io_addr = s_q.addr;
  assign io.io_wr = s_q.wr;
  assign io.io_rd = s_q.rd;
  assign io.io_wdata = s_q.wdata;

endmodule // cpgw_host

// file: cpgw_asserts.sv
/*
  checker of the byte-wide i/o link between host and device.
  assumes it sits beside the interface, clocked by ref_clk.
*/
`timescale 1ns/10ps
module cpgw_asserts
  import cpgw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_ready
);
  // ********************
  // unlock tracker
  // ********************
  logic req;
  logic port;
  logic [7:0] key;
  logic [2:0] keys_q;
  logic [2:0] keys_d;
  assign req = io_wr || io_rd;
  assign port = io_addr == ADDR_PORT || io_addr == DATA_PORT;
  assign key = keys_q == 3'h0 ? KEY_FIRST : (keys_q == 3'h1 ? KEY_SECOND : KEY_THIRD);
  assign keys_d = keys_q == 3'h4 ? (io_wdata == LOCK_KEY ? 3'h0 : 3'h4)
                : (io_wdata == key ? keys_q + 3'h1 : 3'h0);
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
      keys_q <= 3'h0;
    else if (io_wr && io_ready && io_addr == ADDR_PORT)
      keys_q <= keys_d;
  // ********************
  // link properties
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_answer; req && port && !io_ready |=> io_ready; endproperty
  property p_pulse; io_ready |=> !io_ready; endproperty
  property p_cause; io_ready |-> $past(req) && $past(port); endproperty
  property p_drop; io_ready |=> !req; endproperty
  property p_hold; req && !io_ready |=> req && $stable(io_addr) && $stable(io_wdata); endproperty
  property p_excl; !(io_wr && io_rd); endproperty
  property p_rhold; io_ready && !$past(io_rd) |-> $stable(io_rdata); endproperty
  property p_locked;
    io_ready && $past(io_rd) && io_addr == DATA_PORT && keys_q != 3'h4 |-> io_rdata == IDLE_READ;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_cause: assert property (p_cause) else $error("ready without request");
  a_drop: assert property (p_drop) else $error("request kept after ready");
  a_hold: assert property (p_hold) else $error("request changed before ready");
  a_excl: assert property (p_excl) else $error("read and write together");
  a_rhold: assert property (p_rhold) else $error("read data changed by write");
  a_locked: assert property (p_locked) else $error("locked read not idle byte");
  c_write: cover property (io_wr && io_ready && io_addr == DATA_PORT);
  c_read: cover property (io_rd && io_ready && io_addr == DATA_PORT);
  c_open: cover property (keys_q == 3'h4);
endmodule // cpgw_asserts

// file: cpgw_bench.sv
/*
  bench of host and device joined by the i/o link.
  assumes package, interface and both ends are compiled first.
*/
`timescale 1ns/10ps
module cpgw_bench
  import cpgw_pkg::*;
;
  // ********************
  // signals and ends
  // ********************
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] gpi_pins = 8'h00;
  logic [7:0] gpo_pins;
  logic wdt_reset;
  logic irq;
  logic clk_en = 1'b1;
  logic [31:0] rd;
  logic [7:0] v;
  logic [7:0] pulses = 8'h00;
  logic [7:0] keys [4] = '{KEY_FIRST, KEY_SECOND, KEY_THIRD, KEY_THIRD};
  int fails = 0;
  int compares = 0;
  int n;
  cpgw_io_if io ();
  cpgw_host u_cpgw_host (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .io(io.host));
  cpgw_device #(.TICK_CNT(4)) u_cpgw_device (.ref_clk(ref_clk), .rstn(rstn),
    .clk_en(clk_en), .io(io.dev), .gpi_pins(gpi_pins), .gpo_pins(gpo_pins),
    .wdt_reset(wdt_reset), .irq(irq));
  cpgw_asserts u_cpgw_asserts (.ref_clk(ref_clk), .rstn(rstn), .io_addr(io.io_addr),
    .io_wr(io.io_wr), .io_rd(io.io_rd), .io_wdata(io.io_wdata),
    .io_rdata(io.io_rdata), .io_ready(io.io_ready));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (wdt_reset === 1'b1)
      pulses <= pulses + 8'h01;
  // ********************
  // access tasks
  // ********************
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic io_op(input logic p, input logic r, input logic [7:0] b);
    av(HOST_CMD, 1'b1, {22'h0, r, p, b});
    do av(HOST_STS, 1'b0, 32'h0); while (rd[STS_BUSY_BIT] !== 1'b0);
  endtask
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    io_op(1'b0, 1'b0, i);
    io_op(1'b1, 1'b0, d);
  endtask
  task automatic rreg(input logic [7:0] i);
    io_op(1'b0, 1'b0, i);
    io_op(1'b1, 1'b1, 8'h00);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #250_000;
    fails++;
    summarize();
  end
  // ********************
  // tests
  // ********************
  initial
  begin
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    av(4'h8, 1'b0, 32'h0);
    chk(rd[7:0], 8'h00);
    io_op(1'b0, 1'b0, KEY_FIRST);
    io_op(1'b0, 1'b0, KEY_THIRD);
    foreach (keys[k]) io_op(1'b0, 1'b0, keys[k + 1 > 3 ? 3 : k + 1]);
    io_op(1'b1, 1'b1, 8'h00);
    chk(rd[7:0], IDLE_READ);
    foreach (keys[k]) io_op(1'b0, 1'b0, keys[k]);
    wreg(IDX_LDN, LDN_GPIO);
    rreg(IDX_LDN);
    chk(rd[7:0], LDN_GPIO);
    io_op(1'b0, 1'b0, LOCK_KEY);
    io_op(1'b1, 1'b0, LDN_WDT);
    io_op(1'b1, 1'b1, 8'h00);
    chk(rd[7:0], IDLE_READ);
    foreach (keys[k]) io_op(1'b0, 1'b0, keys[k]);
    rreg(IDX_LDN);
    chk(rd[7:0], LDN_GPIO);
    $display("test lock done");
    wreg(IDX_GPO_DATA, 8'h82);
    chk(gpo_pins, 8'h82);
    rreg(IDX_GPO_DATA);
    chk(rd[7:0], 8'h82);
    wreg(IDX_OUT_PORT, 8'h5A);
    wreg(IDX_IN_PORT, 8'hC3);
    rreg(IDX_OUT_PORT);
    chk(rd[7:0], 8'h5A);
    rreg(IDX_IN_PORT);
    chk(rd[7:0], 8'hC3);
    gpi_pins <= 8'hA5;
    rreg(IDX_GPI_DATA);
    chk(rd[7:0], 8'hA5);
    $display("test gpio done");
    wreg(IDX_LDN, LDN_WDT);
    wreg(IDX_WDT_TO, 8'h40);
    rreg(IDX_WDT_TO);
    chk(rd[7:0], 8'h40);
    wreg(IDX_WDT_ACT, WDT_ON);
    wreg(IDX_WDT_CTL, CNT_START);
    rreg(IDX_WDT_TO);
    chk({7'h0, rd[7:0] < 8'h40 && rd[7:0] > 8'h30}, 8'h01);
    repeat (80) @(posedge ref_clk);
    wreg(IDX_WDT_TO, 8'h40);
    rreg(IDX_WDT_TO);
    chk({7'h0, rd[7:0] > 8'h36}, 8'h01);
    wreg(IDX_WDT_ACT, RST_BYTE);
    rreg(IDX_WDT_TO);
    v = rd[7:0];
    rreg(IDX_WDT_TO);
    chk(rd[7:0], v);
    wreg(IDX_WDT_ACT, WDT_ON);
    wreg(IDX_WDT_CTL, RST_BYTE);
    rreg(IDX_WDT_TO);
    v = rd[7:0];
    rreg(IDX_WDT_TO);
    chk(rd[7:0], v);
    chk(pulses, 8'h00);
    $display("test wdt done");
    wreg(IDX_WDT_TO, 8'h02);
    wreg(IDX_WDT_CTL, CNT_START);
    clk_en <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(pulses, 8'h00);
    clk_en <= 1'b1;
    n = 0;
    while (pulses == 8'h00 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    chk(pulses, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rreg(IDX_WDT_TO);
    chk(rd[7:0], 8'h00);
    rreg(IDX_WDT_STS);
    chk(rd[7:0], 8'h01);
    wreg(IDX_WDT_IEN, 8'h01);
    chk({7'h0, irq}, 8'h01);
    wreg(IDX_WDT_CLR, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rreg(IDX_WDT_STS);
    chk(rd[7:0], 8'h00);
    $display("test irq done");
    summarize();
  end
endmodule // cpgw_bench
